// >>> src/asrc_pkg.sv
// Purpose: Constants for the asynchronous static memory controller
// Assumes: 125 MHz controller clock, 45 ns speed grade memory
// Notes:   Times are in ns; cycle counts derive from them
package asrc_pkg;
	// ****************************************
	// Widths
	// ****************************************
	localparam int ADDR_W = 19;
	localparam int DATA_W = 16;
	localparam int LANE_W = 8;
	localparam int CNT_W = 4;
	// ****************************************
	// Timing
	// ****************************************
	localparam int CLK_PERIOD_NS = 8;
	localparam int T_RC_NS = 45;   // Read cycle and address to data
	localparam int T_PWE_NS = 35;  // Write strobe width
	localparam int T_SD_NS = 25;   // Data setup to write end
	localparam int T_HZ_NS = 18;   // Memory release after strobe or select
	localparam int T_HD_NS = 0;    // Data hold after write end
	// Least times round up to whole cycles, never below one
	function automatic int asrc_cyc_up(input int ns);
		int c;
		c = (ns + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
		return (c < 1) ? 1 : c;
	endfunction : asrc_cyc_up
	localparam logic [CNT_W-1:0] RD_CYC = CNT_W'(asrc_cyc_up(T_RC_NS));
	localparam int WR_NS = (T_PWE_NS > T_SD_NS) ? T_PWE_NS : T_SD_NS;
	localparam logic [CNT_W-1:0] WR_CYC = CNT_W'(asrc_cyc_up(WR_NS));
	localparam logic [CNT_W-1:0] TURN_CYC = CNT_W'(asrc_cyc_up(T_HZ_NS));
	localparam logic [CNT_W-1:0] HOLD_CYC = CNT_W'(asrc_cyc_up(T_HD_NS));
	localparam logic [CNT_W-1:0] CNT_ONE = 4'h1;
	localparam logic [CNT_W-1:0] CNT_ZERO = 4'h0;
	// ****************************************
	// States
	// ****************************************
	typedef enum logic [4:0] {
		ASRC_IDLE = 5'h01,
		ASRC_TURN = 5'h02,
		ASRC_READ = 5'h04,
		ASRC_WRITE = 5'h08,
		ASRC_HOLD = 5'h10
	} asrc_state_t;
endpackage : asrc_pkg

// >>> src/asrc_rst_sync.sv
// Purpose: Reset release synchroniser
// Assumes: Active low asynchronous reset input
// Notes:   Assertion is immediate, release takes two edges
`timescale 1ns/10ps
`default_nettype none
module asrc_rst_sync (
	input wire logic clk_i,
	input wire logic resetn_i,
	output logic resetn_o
);
	logic meta_reg;
	logic sync_reg;
	// Two flops so release never lands mid-setup
	always_ff @(posedge clk_i or negedge resetn_i) begin
		if (!resetn_i) begin
			meta_reg <= 1'b0;
			sync_reg <= 1'b0;
		end else begin
			meta_reg <= 1'b1;
			sync_reg <= meta_reg;
		end
	end
	assign resetn_o = sync_reg;
endmodule : asrc_rst_sync
`default_nettype wire

// >>> src/asrc_ctrl.sv
// Purpose: Controller driving an asynchronous x16 static memory with byte lanes
// Assumes: One request at a time; memory pins sampled synchronously
// Notes:   All pin outputs come from flops, so pins never glitch
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - Deselect memory: lanes high when idle
// - Hold data stable past terminating edge
// - Never drive pins while memory drives
// - Write strobe high for every read
// - Address valid before selects go active
// - Strobe alone ends each write; selects and lanes drop one edge later
// - Chip selects always driven definite levels
module asrc_ctrl
	import asrc_pkg::*;
(
	input wire logic clk_i,
	input wire logic resetn_i,
	input wire logic req_i,
	input wire logic req_write_i,
	input wire logic [ADDR_W-1:0] req_addr_i,
	input wire logic [DATA_W-1:0] req_wdata_i,
	input wire logic [1:0] req_lane_en_i,
	output logic req_ready_o,
	output logic rd_valid_o,
	output logic [DATA_W-1:0] rd_data_o,
	output logic [ADDR_W-1:0] mem_addr_o,
	output logic select_active_low_o,
	output logic select_active_high_o,
	output logic write_strobe_n_o,
	output logic out_drive_n_o,
	output logic high_half_lane_n_o,
	output logic low_half_lane_n_o,
	input wire logic [DATA_W-1:0] mem_data_i,
	output logic [DATA_W-1:0] mem_data_o,
	output logic mem_data_oe_o
);
	// ****************************************
	// Reset
	// ****************************************
	logic rstn;
	asrc_rst_sync u_rst (
		.clk_i(clk_i),
		.resetn_i(resetn_i),
		.resetn_o(rstn)
	);

	// ****************************************
	// Sequencer
	// ****************************************
	asrc_state_t state_reg, state_next;
	logic [CNT_W-1:0] cnt_reg, cnt_next;
	logic wr_reg, wr_next;
	logic [1:0] lane_reg, lane_next;
	logic ready_reg, ready_next;
	logic rv_reg, rv_next;
	logic [DATA_W-1:0] rdat_reg, rdat_next;
	logic [ADDR_W-1:0] addr_reg, addr_next;
	logic sel_reg, sel_next;
	logic sel_n_reg, sel_n_next;
	logic we_n_reg, we_n_next;
	logic oe_n_reg, oe_n_next;
	logic [1:0] ln_n_reg, ln_n_next;
	logic [DATA_W-1:0] wd_reg, wd_next;
	logic doe_reg, doe_next;

	// Next state and pin values for each phase
	always_comb begin
		state_next = state_reg;
		cnt_next = cnt_reg;
		wr_next = wr_reg;
		lane_next = lane_reg;
		ready_next = ready_reg;
		rv_next = 1'b0;
		rdat_next = rdat_reg;
		addr_next = addr_reg;
		sel_next = sel_reg;
		we_n_next = we_n_reg;
		oe_n_next = oe_n_reg;
		ln_n_next = ln_n_reg;
		wd_next = wd_reg;
		doe_next = doe_reg;
		if (cnt_reg != CNT_ZERO) begin
			cnt_next = cnt_reg - CNT_ONE;
		end
		unique case (state_reg)
			ASRC_IDLE: begin
				// Ready comes back one edge after reset release
				if (!ready_reg) begin
					ready_next = 1'b1;
				end
				if (req_i && ready_reg && req_lane_en_i != 2'h0) begin
					ready_next = 1'b0;
					wr_next = req_write_i;
					lane_next = req_lane_en_i;
					addr_next = req_addr_i; // Address first, selects next edge
					wd_next = req_wdata_i;
					state_next = ASRC_TURN;
					cnt_next = CNT_ONE;
				end
			end
			ASRC_TURN: begin
				if (cnt_reg == CNT_ONE) begin
					// All controls go active on one edge
					sel_next = 1'b1;
					ln_n_next = ~lane_reg;
					if (wr_reg) begin
						we_n_next = 1'b0;
						oe_n_next = 1'b1;
						doe_next = 1'b1; // Memory released since read end
						state_next = ASRC_WRITE;
						cnt_next = WR_CYC;
					end else begin
						we_n_next = 1'b1;
						oe_n_next = 1'b0;
						doe_next = 1'b0;
						state_next = ASRC_READ;
						cnt_next = RD_CYC;
					end
				end
			end
			ASRC_READ: begin
				if (cnt_reg == CNT_ONE) begin
					// Keep only enabled lanes
					rdat_next[LANE_W-1:0] = lane_reg[0] ? mem_data_i[LANE_W-1:0] : 8'h00;
					rdat_next[DATA_W-1:LANE_W] = lane_reg[1] ? mem_data_i[DATA_W-1:LANE_W] : 8'h00;
					rv_next = 1'b1;
					sel_next = 1'b0;
					ln_n_next = 2'h3;
					oe_n_next = 1'b1;
					state_next = ASRC_HOLD;
					cnt_next = TURN_CYC; // Let memory release the bus
				end
			end
			ASRC_WRITE: begin
				if (cnt_reg == CNT_ONE) begin
					we_n_next = 1'b1; // Strobe ends the write alone
					state_next = ASRC_HOLD;
					cnt_next = HOLD_CYC;
				end
			end
			ASRC_HOLD: begin
				if (cnt_reg == CNT_ONE) begin
					sel_next = 1'b0;
					ln_n_next = 2'h3;
					doe_next = 1'b0; // Data held one edge after strobe rise
					ready_next = 1'b1;
					state_next = ASRC_IDLE;
					cnt_next = CNT_ZERO;
				end
			end
			default: begin
				state_next = ASRC_IDLE;
				ready_next = 1'b1;
			end
		endcase
		// Low-active select always the inverse, so both move on one edge
		sel_n_next = ~sel_next;
	end

	// Register stage, all pins come straight from here
	always_ff @(posedge clk_i or negedge rstn) begin
		if (!rstn) begin
			state_reg <= ASRC_IDLE;
			cnt_reg <= CNT_ZERO;
			wr_reg <= 1'b0;
			lane_reg <= 2'h0;
			ready_reg <= 1'b0;
			rv_reg <= 1'b0;
			rdat_reg <= 16'h0000;
			addr_reg <= 19'h00000;
			sel_reg <= 1'b0;
			sel_n_reg <= 1'b1;
			we_n_reg <= 1'b1;
			oe_n_reg <= 1'b1;
			ln_n_reg <= 2'h3;
			wd_reg <= 16'h0000;
			doe_reg <= 1'b0;
		end else begin
			state_reg <= state_next;
			cnt_reg <= cnt_next;
			wr_reg <= wr_next;
			lane_reg <= lane_next;
			ready_reg <= ready_next;
			rv_reg <= rv_next;
			rdat_reg <= rdat_next;
			addr_reg <= addr_next;
			sel_reg <= sel_next;
			sel_n_reg <= sel_n_next;
			we_n_reg <= we_n_next;
			oe_n_reg <= oe_n_next;
			ln_n_reg <= ln_n_next;
			wd_reg <= wd_next;
			doe_reg <= doe_next;
		end
	end

	// Each select straight from its own flop, always definite levels
	assign select_active_low_o = sel_n_reg;
	assign select_active_high_o = sel_reg;
	assign req_ready_o = ready_reg;
	assign rd_valid_o = rv_reg;
	assign rd_data_o = rdat_reg;
	assign mem_addr_o = addr_reg;
	assign write_strobe_n_o = we_n_reg;
	assign out_drive_n_o = oe_n_reg;
	assign high_half_lane_n_o = ln_n_reg[1];
	assign low_half_lane_n_o = ln_n_reg[0];
	assign mem_data_o = wd_reg;
	assign mem_data_oe_o = doe_reg;

	// ****************************************
	// Checks
	// ****************************************
	sequence s_write_start;
		$fell(we_n_reg) && sel_reg;
	endsequence
	sequence s_write_end;
		$rose(we_n_reg) && sel_reg;
	endsequence

	chk_select_pair: assert property (@(posedge clk_i) disable iff (!rstn)
		sel_n_reg == !sel_reg)
		else $error("chip selects disagree");
	chk_idle_deselect: assert property (@(posedge clk_i) disable iff (!rstn)
		state_reg == ASRC_IDLE |-> !sel_reg && ln_n_reg == 2'h3)
		else $error("memory not deselected while idle");
	chk_read_strobe: assert property (@(posedge clk_i) disable iff (!rstn)
		state_reg == ASRC_READ |-> we_n_reg && !doe_reg)
		else $error("strobe low or bus driven during read");
	chk_write_oe: assert property (@(posedge clk_i) disable iff (!rstn)
		!we_n_reg |-> oe_n_reg && doe_reg)
		else $error("output enable low during write");
	chk_write_start: assert property (@(posedge clk_i) disable iff (!rstn)
		s_write_start |-> ln_n_reg != 2'h3 && $rose(sel_reg))
		else $error("write began without all controls");
	chk_write_width: assert property (@(posedge clk_i) disable iff (!rstn)
		s_write_start |-> !we_n_reg [*5] ##1 we_n_reg)
		else $error("write strobe width wrong");
	chk_data_hold: assert property (@(posedge clk_i) disable iff (!rstn)
		s_write_end |-> doe_reg && $stable(wd_reg))
		else $error("write data not held at strobe rise");
	chk_addr_early: assert property (@(posedge clk_i) disable iff (!rstn)
		$rose(sel_reg) |-> $stable(addr_reg))
		else $error("address moved with select");
	chk_read_len: assert property (@(posedge clk_i) disable iff (!rstn)
		$rose(sel_reg) && we_n_reg |-> ##6 rv_reg)
		else $error("read data not returned in time");
	chk_no_contend: assert property (@(posedge clk_i) disable iff (!rstn)
		$fell(oe_n_reg) |-> !doe_reg [*8])
		else $error("bus driven while memory drives");
endmodule : asrc_ctrl
`default_nettype wire

// >>> bench/asrc_sram_model.sv
// Purpose: Behavioural x16 static memory with two byte lanes
// Assumes: Only the low eight address bits are decoded
// Notes:   Undriven lanes show the inverse of the stored byte
`timescale 1ns/10ps
`default_nettype none
module asrc_sram_model
	import asrc_pkg::*;
#(
	parameter int RD_DLY_NS = 40
) (
	input wire logic sel_n_i,
	input wire logic sel_i,
	input wire logic we_n_i,
	input wire logic oe_n_i,
	input wire logic hi_n_i,
	input wire logic lo_n_i,
	input wire logic [ADDR_W-1:0] addr_i,
	input wire logic [DATA_W-1:0] data_i,
	input wire logic data_oe_i,
	output logic [DATA_W-1:0] data_o,
	output var logic clash_o
);
	// ****************************************
	// Array and decode
	// ****************************************
	logic [DATA_W-1:0] mem [0:255];
	logic [DATA_W-1:0] word;
	logic sel;
	logic wr_act;
	logic [1:0] drv;
	// Selected only with both selects active and some lane on
	assign sel = ~sel_n_i & sel_i & ~(hi_n_i & lo_n_i);
	assign wr_act = sel & ~we_n_i;
	// Slow access: stale data shows until the delay runs out
	assign #(RD_DLY_NS) word = mem[addr_i[7:0]];
	// Drive only in a read, per lane; never while strobe low
	assign drv = {2{sel & we_n_i & ~oe_n_i}} & ~{hi_n_i, lo_n_i};
	assign data_o = {drv[1] ? word[15:8] : ~word[15:8], drv[0] ? word[7:0] : ~word[7:0]};
	initial begin
		for (int i = 0; i < 256; i++) begin
			mem[i] = 16'h0000;
		end
		clash_o = 1'b0;
	end
	// Latch at the terminating edge, enabled lanes only
	always @(negedge wr_act) begin
		if (lo_n_i === 1'b0) mem[addr_i[7:0]][7:0] <= data_i[7:0];
		if (hi_n_i === 1'b0) mem[addr_i[7:0]][15:8] <= data_i[15:8];
	end
	// Both sides driving is remembered for the bench
	always @* begin
		if (data_oe_i && drv != 2'b00) clash_o = 1'b1;
	end
endmodule : asrc_sram_model
`default_nettype wire

// >>> bench/async_sram_x16_byte_lane_port_tb.sv
// Purpose: Self-checking bench for the static memory controller
// Assumes: Requests one at a time, driven at falling edges
// Notes:   Read latency of eight cycles is checked on every read made through xfer
`timescale 1ns/10ps
`default_nettype none
module async_sram_x16_byte_lane_port_tb
	import asrc_pkg::*;
;
	// ****************************************
	// Signals and instances
	// ****************************************
	logic clk_i = 1'b0;
	logic resetn_i, req_i, req_write_i, req_ready_o, rd_valid_o, sa_lo, sa_hi, we_n, oe_n, hi_n, lo_n, d_oe, clash;
	logic [ADDR_W-1:0] req_addr_i, mem_addr;
	logic [DATA_W-1:0] req_wdata_i, rd_data_o, d_in, d_out, rd;
	logic [1:0] req_lane_en_i;
	int miscompares = 0;
	int n_tests = 0;
	always #4 clk_i = ~clk_i;
	asrc_ctrl uut (.clk_i(clk_i), .resetn_i(resetn_i), .req_i(req_i), .req_write_i(req_write_i),
		.req_addr_i(req_addr_i), .req_wdata_i(req_wdata_i), .req_lane_en_i(req_lane_en_i),
		.req_ready_o(req_ready_o), .rd_valid_o(rd_valid_o), .rd_data_o(rd_data_o), .mem_addr_o(mem_addr),
		.select_active_low_o(sa_lo), .select_active_high_o(sa_hi), .write_strobe_n_o(we_n),
		.out_drive_n_o(oe_n), .high_half_lane_n_o(hi_n), .low_half_lane_n_o(lo_n),
		.mem_data_i(d_in), .mem_data_o(d_out), .mem_data_oe_o(d_oe));
	asrc_sram_model #(.RD_DLY_NS(40)) mdl (.sel_n_i(sa_lo), .sel_i(sa_hi), .we_n_i(we_n), .oe_n_i(oe_n),
		.hi_n_i(hi_n), .lo_n_i(lo_n), .addr_i(mem_addr), .data_i(d_oe ? d_out : ~d_out),
		.data_oe_i(d_oe), .data_o(d_in), .clash_o(clash));
	// ****************************************
	// Tasks
	// ****************************************
	task automatic check(input logic [DATA_W-1:0] seen, input logic [DATA_W-1:0] exp);
		n_tests++;
		if (seen !== exp) begin
			miscompares++;
			$display("ERROR at %0t: seen %h expected %h", $time, seen, exp);
		end
	endtask : check
	task automatic summarize();
		$display("Comparisons %0d, mismatches %0d", n_tests, miscompares);
		if (miscompares == 0 && n_tests > 0) $display("Testbench passed");
		else $display("Testbench failed");
		$finish;
	endtask : summarize
	// One request; a read also returns its data and checks latency
	task automatic xfer(input logic w, input logic [ADDR_W-1:0] a, input logic [DATA_W-1:0] d,
		input logic [1:0] ln, output logic [DATA_W-1:0] q);
		int n;
		n = 0;
		while (req_ready_o !== 1'b1 && n < 40) begin
			@(negedge clk_i);
			n++;
		end
		check({15'h0, req_ready_o}, 16'h0001);
		{req_i, req_write_i, req_addr_i, req_wdata_i, req_lane_en_i} = {1'b1, w, a, d, ln};
		@(negedge clk_i);
		req_i = 1'b0;
		n = 1;
		while (!w && rd_valid_o !== 1'b1 && n < 20) begin
			@(negedge clk_i);
			n++;
		end
		q = rd_data_o;
		if (!w) begin
			check(16'(n), 16'h0008);
			check({15'h0, we_n}, 16'h0001);
			check(mem_addr[18:3], a[18:3]);
		end
	endtask : xfer
	// Write full word, patch low lane, read full and one lane
	task automatic t_lanes();
		xfer(1'b1, 19'h00010, 16'h5aa5, 2'b11, rd);
		xfer(1'b0, 19'h00010, 16'h0000, 2'b11, rd);
		check(rd, 16'h5aa5);
		xfer(1'b1, 19'h00010, 16'h1234, 2'b01, rd);
		xfer(1'b0, 19'h00010, 16'h0000, 2'b11, rd);
		check(rd, 16'h5a34);
		xfer(1'b0, 19'h00010, 16'h0000, 2'b10, rd);
		check(rd, 16'h5a00);
	endtask : t_lanes
	// Back-to-back reads of different words; high address bits reach the pins
	task automatic t_b2b();
		xfer(1'b1, 19'h00021, 16'hc3e1, 2'b11, rd);
		xfer(1'b0, 19'h7ff10, 16'h0000, 2'b11, rd);
		check(rd, 16'h5a34);
		xfer(1'b0, 19'h00021, 16'h0000, 2'b11, rd);
		check(rd, 16'hc3e1);
	endtask : t_b2b
	// A request with no lanes leaves the memory deselected
	task automatic t_refuse();
		@(negedge clk_i);
		{req_i, req_write_i, req_lane_en_i} = {1'b1, 1'b1, 2'b00};
		repeat (3) @(negedge clk_i);
		check({14'h0, req_ready_o, sa_lo}, 16'h0003);
		req_i = 1'b0;
	endtask : t_refuse
	// Reset in mid-read drops every control at once; stored words survive
	task automatic t_reset();
		@(negedge clk_i);
		{req_i, req_write_i, req_addr_i, req_lane_en_i} = {1'b1, 1'b0, 19'h00021, 2'b11};
		repeat (3) @(negedge clk_i);
		{resetn_i, req_i} = 2'b00;
		@(negedge clk_i);
		check({13'h0, req_ready_o, sa_lo, oe_n}, 16'h0003);
		resetn_i = 1'b1;
		xfer(1'b0, 19'h00021, 16'h0000, 2'b11, rd);
		check(rd, 16'hc3e1);
	endtask : t_reset
	// ****************************************
	// Main sequence and watchdog
	// ****************************************
	initial begin
		{resetn_i, req_i, req_write_i, req_addr_i, req_wdata_i, req_lane_en_i} = '0;
		repeat (10) @(negedge clk_i);
		check({7'h0, req_ready_o, rd_valid_o, sa_lo, sa_hi, we_n, oe_n, hi_n, lo_n, d_oe}, 16'h005e);
		resetn_i = 1'b1;
		t_lanes();
		t_b2b();
		t_refuse();
		t_reset();
		check({15'h0, clash}, 16'h0000);
		summarize();
	end
	// Whole run is about 110 cycles; far longer means a hang
	initial begin
		#20000;
		miscompares++;
		summarize();
	end
endmodule : async_sram_x16_byte_lane_port_tb
`default_nettype wire
